// *** logic/iap_flash_self_programmer.sv ***
// flash self-programming controller: ahb-lite register file, page write buffer and flash sequencer
//
// Summary of operation
// - erase and write act on whole 32-word pages; read acts on one word
// - erase/write enabled flag rises only after a successful unlock
// - write buffer accepts words only while erase/write enabled flag is high
// - write trigger stays high during the write, hardware clears it at the end
// - flash reads happen only while read enable is set
// - read trigger cleared by hardware when read data is in the first data pair
// - page number is address bits 12..5, word in page is bits 4..0
// - clear-buffer trigger runs the buffer clear, then hardware drops it
// - first low byte write only stores; first high byte write loads the word
// - after each loaded word the address increments by one
// - at word offset 11111b the address stops at the page's last word
// - buffer cleared automatically when a write finishes
// - two address, four 16-bit data pairs, three control registers; 8-bit transfers
// - mode 000 write, 001 erase, 011 read, 110 unlock; others reserved
// - unlock trigger starts a timer and is cleared at timeout
// - software may clear the enabled flag but never set it
module iap_flash_self_programmer #(
  parameter logic [15:0] UNLOCK_CYC = 16'(`UNLOCK_CYC),
  // unlock patterns; values are arbitrary
  parameter logic [15:0] PATTERN1 = 16'h1234,
  parameter logic [15:0] PATTERN2 = 16'h5678,
  parameter logic [15:0] PATTERN3 = 16'h9abc
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output iap_pkg::flash_cmd_t flash_cmd_o,
  input wire logic flash_ack_i,
  input wire logic [15:0] flash_rdata_i
);

  typedef struct packed {
    iap_pkg::state_t st;
    logic ew_flag;
    logic [2:0] mode;
    logic utrig;
    logic wtrig;
    logic rden;
    logic rtrig;
    logic clrb;
    logic [7:0] aux;
    logic [`ADDR_W-1:0] addr;
    logic [3:0][`WORD_W-1:0] fd;
    logic [`PAGE_WORDS-1:0][`WORD_W-1:0] wbuf;
    logic [4:0] idx;
    logic [15:0] timer;
    iap_pkg::flash_cmd_t f;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic hrdy;
  } regs_t;

  regs_t r;
  regs_t n;
  logic [7:0] wd;

  function automatic logic [7:0] reg_read(input regs_t s, input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `OFS_CTRL_MAIN: v = {s.ew_flag, s.mode, s.utrig, s.wtrig, s.rden, s.rtrig};
      `OFS_CTRL_AUX: v = s.aux;
      `OFS_BUF_CLR: v = {7'h00, s.clrb};
      `OFS_ADDR_LO: v = s.addr[7:0];
      `OFS_ADDR_HI: v = {3'h0, s.addr[12:8]};
      `OFS_DATA0_LO: v = s.fd[0][7:0];
      `OFS_DATA0_HI: v = s.fd[0][15:8];
      `OFS_DATA1_LO: v = s.fd[1][7:0];
      `OFS_DATA1_HI: v = s.fd[1][15:8];
      `OFS_DATA2_LO: v = s.fd[2][7:0];
      `OFS_DATA2_HI: v = s.fd[2][15:8];
      `OFS_DATA3_LO: v = s.fd[3][7:0];
      `OFS_DATA3_HI: v = s.fd[3][15:8];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  assign wd = hwdata_i[7:0];

  always_comb begin
    n = r;
    n.rdata = 32'h0000_0000;
    n.hrdy = 1'b1;
    // data phase of a register write
    if (r.ph_wr) begin
      case (r.ph_addr)
        `OFS_CTRL_MAIN: begin
          if (!wd[`BIT_EW_FLAG]) begin
            n.ew_flag = 1'b0;
          end
          n.mode = wd[`BIT_MODE_HI:`BIT_MODE_LO];
          n.rden = wd[`BIT_READ_EN];
          if (r.st == iap_pkg::S_IDLE) begin
            n.utrig = wd[`BIT_UNLOCK_TRIG] && (n.mode == iap_pkg::MODE_UNLOCK);
            n.wtrig = wd[`BIT_WRITE_TRIG];
            n.rtrig = wd[`BIT_READ_TRIG];
            n.timer = UNLOCK_CYC;
          end
        end
        `OFS_CTRL_AUX: n.aux = wd;
        `OFS_BUF_CLR: begin
          if (r.st == iap_pkg::S_IDLE) begin
            n.clrb = wd[`BIT_CLR_TRIG];
          end
        end
        `OFS_ADDR_LO: n.addr[7:0] = wd;
        `OFS_ADDR_HI: n.addr[12:8] = wd[4:0];
        `OFS_DATA0_LO: n.fd[0][7:0] = wd;
        `OFS_DATA0_HI: begin
          n.fd[0][15:8] = wd;
          // loads only when idle so a running page write sees a steady buffer
          if (r.ew_flag && r.st == iap_pkg::S_IDLE) begin
            n.wbuf[r.addr[4:0]] = {wd, r.fd[0][7:0]};
            if (r.addr[4:0] != `LAST_WORD) begin
              n.addr = r.addr + 13'h0001;
            end
          end
        end
        `OFS_DATA1_LO: n.fd[1][7:0] = wd;
        `OFS_DATA1_HI: n.fd[1][15:8] = wd;
        `OFS_DATA2_LO: n.fd[2][7:0] = wd;
        `OFS_DATA2_HI: n.fd[2][15:8] = wd;
        `OFS_DATA3_LO: n.fd[3][7:0] = wd;
        `OFS_DATA3_HI: n.fd[3][15:8] = wd;
        default: n.aux = r.aux;
      endcase
    end
    // sequencer
    case (r.st)
      iap_pkg::S_IDLE: begin
        if (n.utrig) begin
          n.st = iap_pkg::S_UNLOCK;
        end else if (n.clrb) begin
          n.st = iap_pkg::S_CLEAR;
        end else if (n.wtrig) begin
          if (n.ew_flag && n.mode == iap_pkg::MODE_WRITE) begin
            n.st = iap_pkg::S_WRITE;
            n.idx = 5'h00;
          end else if (n.ew_flag && n.mode == iap_pkg::MODE_ERASE) begin
            n.st = iap_pkg::S_ERASE;
          end else begin
            n.wtrig = 1'b0;
          end
        end else if (n.rtrig) begin
          if (n.rden && n.mode == iap_pkg::MODE_READ) begin
            n.st = iap_pkg::S_READ;
          end else begin
            n.rtrig = 1'b0;
          end
        end
      end
      iap_pkg::S_UNLOCK: begin
        // hardware set comes after the software clear, so the set wins
        if (r.fd[1] == PATTERN1 && r.fd[2] == PATTERN2 && r.fd[3] == PATTERN3) begin
          n.ew_flag = 1'b1;
        end
        n.timer = r.timer - 16'h0001;
        if (r.timer <= 16'h0001) begin
          n.utrig = 1'b0;
          n.st = iap_pkg::S_IDLE;
        end
      end
      iap_pkg::S_CLEAR: begin
        n.wbuf = {`PAGE_WORDS{`BUF_CLEAR_WORD}};
        n.clrb = 1'b0;
        n.st = iap_pkg::S_IDLE;
      end
      iap_pkg::S_WRITE: begin
        if (r.f.req && flash_ack_i) begin
          n.f.req = 1'b0;
          n.idx = r.idx + 5'h01;
          if (r.idx == `LAST_WORD) begin
            n.wtrig = 1'b0;
            n.st = iap_pkg::S_CLEAR;
          end
        end else begin
          n.f.req = 1'b1;
          n.f.op = iap_pkg::FOP_WRITE;
          n.f.addr = {r.addr[12:`PAGE_LSB], r.idx};
          n.f.wdata = r.wbuf[r.idx];
        end
      end
      iap_pkg::S_ERASE: begin
        if (r.f.req && flash_ack_i) begin
          n.f.req = 1'b0;
          n.wtrig = 1'b0;
          n.st = iap_pkg::S_IDLE;
        end else begin
          n.f.req = 1'b1;
          n.f.op = iap_pkg::FOP_ERASE;
          n.f.addr = {r.addr[12:`PAGE_LSB], 5'h00};
        end
      end
      iap_pkg::S_READ: begin
        if (r.f.req && flash_ack_i) begin
          n.f.req = 1'b0;
          n.fd[0] = flash_rdata_i;
          n.rtrig = 1'b0;
          n.st = iap_pkg::S_IDLE;
        end else if (!n.rden && !r.f.req) begin
          n.rtrig = 1'b0;
          n.st = iap_pkg::S_IDLE;
        end else begin
          n.f.req = 1'b1;
          n.f.op = iap_pkg::FOP_READ;
          n.f.addr = r.addr;
        end
      end
      default: n.st = iap_pkg::S_IDLE;
    endcase
    // address phase; read data taken from next state so a read right after a write sees it
    n.ph_wr = hsel_i && htrans_i[1] && hready_i && hwrite_i;
    n.ph_addr = haddr_i[7:0];
    if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
      n.rdata = {24'h000000, reg_read(n, haddr_i[7:0])};
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.hrdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hrdata_o = r.rdata;
  assign hreadyout_o = r.hrdy;
  assign hresp_o = 1'b0;
  assign flash_cmd_o = r.f;

  // checks
  logic wr_first_hi;
  logic wr_main;
  assign wr_first_hi = r.ph_wr && r.ph_addr == `OFS_DATA0_HI && r.st == iap_pkg::S_IDLE;
  assign wr_main = r.ph_wr && r.ph_addr == `OFS_CTRL_MAIN;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_BUF_LOCKED: assert property (wr_first_hi && !r.ew_flag |=> r.wbuf == $past(r.wbuf))
    else $error("buffer changed while erase/write disabled");
  AST_ADDR_INC: assert property (wr_first_hi && r.ew_flag && r.addr[4:0] != `LAST_WORD
    |=> r.addr == $past(r.addr) + 13'h0001 && r.wbuf[$past(r.addr[4:0])] == {$past(wd), $past(r.fd[0][7:0])})
    else $error("word load or address increment wrong");
  AST_ADDR_HOLD: assert property (wr_first_hi && r.ew_flag && r.addr[4:0] == `LAST_WORD
    |=> r.addr == $past(r.addr))
    else $error("address moved past page end");
  AST_FLAG_SET_SRC: assert property ($rose(r.ew_flag) |-> $past(r.st) == iap_pkg::S_UNLOCK)
    else $error("enabled flag set outside unlock");
  AST_WT_HELD: assert property (r.st == iap_pkg::S_WRITE |-> r.wtrig && r.ew_flag)
    else $error("write trigger low during write");
  AST_RD_EN: assert property (r.st == iap_pkg::S_READ && !r.f.req |-> r.rden || !r.rtrig)
    else $error("read issued without read enable");
  AST_RD_DONE: assert property (r.st == iap_pkg::S_READ && r.f.req && flash_ack_i
    |=> !r.rtrig && r.fd[0] == $past(flash_rdata_i) && r.st == iap_pkg::S_IDLE)
    else $error("read completion wrong");
  AST_AUTO_CLEAR: assert property (r.st == iap_pkg::S_WRITE && r.f.req && flash_ack_i && r.idx == `LAST_WORD
    |=> !r.wtrig ##1 r.wbuf == {`PAGE_WORDS{`BUF_CLEAR_WORD}})
    else $error("buffer not cleared after write");
  AST_CLRB_DROP: assert property ($rose(r.clrb) |-> ##[1:2] !r.clrb)
    else $error("clear trigger not dropped");
  AST_UNLOCK_TMO: assert property (r.st == iap_pkg::S_UNLOCK && r.timer == 16'h0001
    |=> !r.utrig && r.st == iap_pkg::S_IDLE)
    else $error("unlock trigger not cleared at timeout");
  AST_BUSY_IGNORE: assert property (r.st == iap_pkg::S_READ && wr_main
    |=> r.wtrig == $past(r.wtrig) && r.utrig == $past(r.utrig))
    else $error("trigger accepted while busy");
  AST_PAGE_ADDR: assert property (r.st == iap_pkg::S_WRITE && r.f.req
    |-> r.f.addr[12:5] == r.addr[12:5])
    else $error("write left the page");
  AST_MODE_ERASE: assert property ($rose(r.st == iap_pkg::S_ERASE) |-> r.mode == iap_pkg::MODE_ERASE)
    else $error("erase without erase mode");

  // bus side: this slave never stalls and never errors, so a wait state or error is a fault

  AST_HRESP_OKAY: assert property (
    hresp_o == 1'b0)
    else $error("error response seen");

  AST_HREADY_HIGH: assert property (
    hreadyout_o == 1'b1)
    else $error("slave inserted a wait state");

  AST_RDATA_UPPER: assert property (
    hrdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  AST_RDATA_IDLE: assert property (!(hsel_i && htrans_i[1] && hready_i && !hwrite_i)
    |=> hrdata_o == 32'h0000_0000)
    else $error("read data outside read data phase");

  // flag: software clears it, only the unlock window may raise it

  AST_FLAG_SW_SET: assert property (wr_main && wd[`BIT_EW_FLAG] && !r.ew_flag && r.st != iap_pkg::S_UNLOCK
    |=> !r.ew_flag)
    else $error("software raised the enabled flag");

  AST_FLAG_SW_CLR: assert property (wr_main && !wd[`BIT_EW_FLAG] && r.st != iap_pkg::S_UNLOCK
    |=> !r.ew_flag)
    else $error("software clear of the enabled flag lost");

  AST_UTRIG_MODE: assert property ($rose(r.utrig)
    |-> r.mode == iap_pkg::MODE_UNLOCK)
    else $error("unlock started outside unlock mode");

  AST_READ_MODE: assert property ($rose(r.st == iap_pkg::S_READ)
    |-> r.mode == iap_pkg::MODE_READ && r.rden)
    else $error("read started without read mode and enable");

  AST_WRITE_MODE: assert property ($rose(r.st == iap_pkg::S_WRITE)
    |-> r.mode == iap_pkg::MODE_WRITE && r.ew_flag && r.idx == 5'h00)
    else $error("write started wrongly");

  AST_CLRB_IDLE: assert property ($rose(r.clrb)
    |-> $past(r.st) == iap_pkg::S_IDLE)
    else $error("clear trigger taken while busy");

  AST_RTRIG_IDLE: assert property ($rose(r.rtrig)
    |-> $past(r.st) == iap_pkg::S_IDLE)
    else $error("read trigger taken while busy");

  AST_CLEAR_FILL: assert property (r.st == iap_pkg::S_CLEAR
    |=> r.wbuf == {`PAGE_WORDS{`BUF_CLEAR_WORD}})
    else $error("buffer clear incomplete");

  // flash link: a request keeps its op and write data until its ack, then drops for at least one cycle

  AST_REQ_HOLD: assert property (r.f.req && !flash_ack_i
    |=> r.f.req && $stable(r.f.op) && $stable(r.f.wdata))
    else $error("flash request changed before ack");

  AST_REQ_DROP: assert property (r.f.req && flash_ack_i
    |=> !r.f.req)
    else $error("flash request not dropped after ack");

  AST_ERASE_ADDR: assert property (r.st == iap_pkg::S_ERASE && r.f.req
    |-> r.f.op == iap_pkg::FOP_ERASE && r.f.addr[4:0] == 5'h00)
    else $error("erase not page aligned");

  AST_READ_ADDR: assert property (r.st == iap_pkg::S_READ && r.f.req
    |-> r.f.op == iap_pkg::FOP_READ && r.f.addr == $past(r.addr))
    else $error("read address wrong");

  AST_WRITE_DATA: assert property (r.st == iap_pkg::S_WRITE && r.f.req
    |-> r.f.op == iap_pkg::FOP_WRITE && r.f.wdata == r.wbuf[r.f.addr[4:0]])
    else $error("write word does not match buffer");

  COV_RD_ABORT: cover property (r.st == iap_pkg::S_READ && !r.rden ##1 r.st == iap_pkg::S_IDLE);
  COV_UNLOCK: cover property ($rose(r.ew_flag));
  COV_WRITE: cover property (r.st == iap_pkg::S_WRITE ##1 r.st == iap_pkg::S_CLEAR);
  COV_ERASE: cover property (r.st == iap_pkg::S_ERASE && flash_ack_i && r.f.req);
  COV_READ: cover property (r.st == iap_pkg::S_READ ##1 r.st == iap_pkg::S_IDLE);

endmodule : iap_flash_self_programmer

// *** logic/iap_consts.svh ***
// offsets, field positions, reset values and timing of the flash self-programming controller
`ifndef IAP_CONSTS_SVH
`define IAP_CONSTS_SVH
`define OFS_CTRL_MAIN 8'h00
`define OFS_CTRL_AUX 8'h04
`define OFS_BUF_CLR 8'h08
`define OFS_ADDR_LO 8'h0c
`define OFS_ADDR_HI 8'h10
`define OFS_DATA0_LO 8'h14
`define OFS_DATA0_HI 8'h18
`define OFS_DATA1_LO 8'h1c
`define OFS_DATA1_HI 8'h20
`define OFS_DATA2_LO 8'h24
`define OFS_DATA2_HI 8'h28
`define OFS_DATA3_LO 8'h2c
`define OFS_DATA3_HI 8'h30
`define BIT_EW_FLAG 7
`define BIT_MODE_HI 6
`define BIT_MODE_LO 4
`define BIT_UNLOCK_TRIG 3
`define BIT_WRITE_TRIG 2
`define BIT_READ_EN 1
`define BIT_READ_TRIG 0
`define BIT_CLR_TRIG 0
`define ADDR_W 13
`define PAGE_LSB 5
`define PAGE_WORDS 32
`define WORD_W 16
`define LAST_WORD 5'h1f
`define RST_BYTE 8'h00
`define RST_ADDR 13'h0000
`define RST_WORD 16'h0000
`define BUF_CLEAR_WORD 16'hffff
`define CLK_MHZ 20
`define UNLOCK_WINDOW_US 100
`define UNLOCK_CYC (`UNLOCK_WINDOW_US * `CLK_MHZ)
`endif

// *** logic/iap_pkg.sv ***
// types of the flash self-programming controller
`include "iap_consts.svh"
package iap_pkg;
  typedef enum logic [2:0] {
    MODE_WRITE = 3'h0,
    MODE_ERASE = 3'h1,
    MODE_READ = 3'h3,
    MODE_UNLOCK = 3'h6
  } mode_t;
  typedef enum logic [1:0] {
    FOP_WRITE = 2'h0,
    FOP_ERASE = 2'h1,
    FOP_READ = 2'h2
  } flash_op_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_UNLOCK = 3'h1,
    S_CLEAR = 3'h2,
    S_WRITE = 3'h3,
    S_ERASE = 3'h4,
    S_READ = 3'h5
  } state_t;
  typedef struct packed {
    logic req;
    flash_op_t op;
    logic [`ADDR_W-1:0] addr;
    logic [`WORD_W-1:0] wdata;
  } flash_cmd_t;
endpackage : iap_pkg

// *** sim/iap_flash_self_programmer_tb.sv ***
// register-level testbench of the flash self-programming controller
`include "iap_consts.svh"
module iap_flash_self_programmer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic hready_i;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  iap_pkg::flash_cmd_t flash_cmd_o;
  logic flash_ack_i = 1'b0;
  logic [15:0] flash_rdata_i = 16'h0;
  int errors = 0;
  int comparisons = 0;
  int req_cnt = 0;
  int req_mark = 0;
  logic [15:0] wv;
  int wait_cnt = 0;
  int i;
  logic [31:0] rdv;
  iap_pkg::flash_op_t exp_op = iap_pkg::FOP_WRITE;
  logic [12:0] exp_base = 13'h0;
  logic exp_fill = 1'b0;

  // short unlock window keeps the run brief
  iap_flash_self_programmer #(.UNLOCK_CYC(16'd60)) DUT (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .flash_cmd_o(flash_cmd_o), .flash_ack_i(flash_ack_i), .flash_rdata_i(flash_rdata_i));
  assign hready_i = hreadyout_o;

  always #25 clock_i = ~clock_i;

  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [15:0] wword(input int n);
    return {8'h40 + 8'(n), 8'hc0 ^ 8'(n)};
  endfunction : wword

  // prompt and slow answers alternate; read data toggles outside the ack cycle
  always @(posedge clock_i) begin
    flash_ack_i <= 1'b0;
    flash_rdata_i <= ~flash_rdata_i;
    if (flash_cmd_o.req === 1'b1 && flash_ack_i === 1'b0) begin
      if (wait_cnt < (req_cnt % 2) * 3) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        flash_ack_i <= 1'b1;
        flash_rdata_i <= 16'hc3a5;
        check({30'h0, flash_cmd_o.op}, {30'h0, exp_op});
        check({19'h0, flash_cmd_o.addr}, {19'h0, exp_base + 13'(req_cnt - req_mark)});
        if (exp_op == iap_pkg::FOP_WRITE) begin
          check({16'h0, flash_cmd_o.wdata}, {16'h0, exp_fill ? 16'hffff : wword(req_cnt - req_mark)});
        end
        req_cnt <= req_cnt + 1;
      end
    end
  end

  // one single ahb-lite transfer; read data is taken at the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [7:0] wd);
    int n;
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, ofs};
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    n = 0;
    @(posedge clock_i);
    while (hready_i !== 1'b1 && n < 100) begin
      n++;
      @(posedge clock_i);
    end
    htrans_i <= 2'b00;
    hwdata_i <= {24'h0, wd};
    @(posedge clock_i);
    while (hready_i !== 1'b1 && n < 100) begin
      n++;
      @(posedge clock_i);
    end
    rdv = hrdata_o;
    if (n >= 100) begin
      errors++;
      give_verdict();
    end
  endtask : bus

  task automatic wr(input logic [7:0] ofs, input logic [7:0] wd);
    bus(1'b1, ofs, wd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    bus(1'b0, ofs, 8'h0);
    check(rdv, {24'h0, exp});
    check({31'h0, hresp_o}, 32'h0);
  endtask : rd_chk

  // hardware-cleared bits: bounded polling, never open-ended
  task automatic poll(input logic [7:0] ofs, input logic [7:0] mask);
    int n;
    n = 0;
    bus(1'b0, ofs, 8'h0);
    while ((rdv[7:0] & mask) !== 8'h0 && n < 300) begin
      n++;
      bus(1'b0, ofs, 8'h0);
    end
    if (n >= 300) begin
      errors++;
      give_verdict();
    end
  endtask : poll

  task automatic unlock(input logic [15:0] p1);
    wr(`OFS_CTRL_MAIN, 8'h68);
    wr(`OFS_DATA1_LO, p1[7:0]);
    wr(`OFS_DATA1_HI, p1[15:8]);
    wr(`OFS_DATA2_LO, 8'h78);
    wr(`OFS_DATA2_HI, 8'h56);
    wr(`OFS_DATA3_LO, 8'hbc);
    wr(`OFS_DATA3_HI, 8'h9a);
    poll(`OFS_CTRL_MAIN, 8'h08);
  endtask : unlock

  task automatic run_write(input logic fill);
    exp_op = iap_pkg::FOP_WRITE;
    exp_base = 13'h120;
    exp_fill = fill;
    req_mark = req_cnt;
    wr(`OFS_CTRL_MAIN, 8'h84);
    rd_chk(`OFS_CTRL_MAIN, 8'h84);
    poll(`OFS_CTRL_MAIN, 8'h04);
    check(rdv, 32'h80);
    check(32'(req_cnt - req_mark), 32'd32);
  endtask : run_write

  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (i = 0; i <= 13; i++) begin
      rd_chk(8'(i * 4), `RST_BYTE);
    end
    wr(8'h34, 8'h5a);
    rd_chk(8'h34, 8'h00);
    wr(`OFS_CTRL_MAIN, 8'h80);
    rd_chk(`OFS_CTRL_MAIN, 8'h00);
    unlock(16'h1235);
    check(rdv, 32'h60);
    unlock(16'h1234);
    check(rdv, 32'he0);
    wr(`OFS_BUF_CLR, 8'h01);
    poll(`OFS_BUF_CLR, 8'h01);
    check(rdv, 32'h0);
    wr(`OFS_ADDR_LO, 8'h20);
    wr(`OFS_ADDR_HI, 8'h01);
    for (i = 0; i < 32; i++) begin
      wv = wword(i);
      wr(`OFS_DATA0_LO, wv[7:0]);
      if (i == 0) rd_chk(`OFS_ADDR_LO, 8'h20);
      wr(`OFS_DATA0_HI, wv[15:8]);
      if (i == 0) rd_chk(`OFS_ADDR_LO, 8'h21);
    end
    rd_chk(`OFS_ADDR_LO, 8'h3f);
    rd_chk(`OFS_ADDR_HI, 8'h01);
    wr(`OFS_ADDR_LO, 8'h20);
    exp_op = iap_pkg::FOP_ERASE;
    exp_base = 13'h120;
    req_mark = req_cnt;
    wr(`OFS_CTRL_MAIN, 8'h94);
    poll(`OFS_CTRL_MAIN, 8'h04);
    check(rdv, 32'h90);
    check(32'(req_cnt - req_mark), 32'd1);
    run_write(1'b0);
    run_write(1'b1);
    wr(`OFS_CTRL_MAIN, 8'h00);
    rd_chk(`OFS_CTRL_MAIN, 8'h00);
    wr(`OFS_DATA0_HI, 8'h11);
    rd_chk(`OFS_ADDR_LO, 8'h20);
    wr(`OFS_CTRL_MAIN, 8'h04);
    rd_chk(`OFS_CTRL_MAIN, 8'h00);
    wr(`OFS_ADDR_LO, 8'h23);
    exp_op = iap_pkg::FOP_READ;
    exp_base = 13'h123;
    req_mark = req_cnt;
    wr(`OFS_CTRL_MAIN, 8'h31);
    rd_chk(`OFS_CTRL_MAIN, 8'h30);
    check(32'(req_cnt - req_mark), 32'd0);
    wr(`OFS_CTRL_MAIN, 8'h32);
    wr(`OFS_CTRL_MAIN, 8'h33);
    poll(`OFS_CTRL_MAIN, 8'h01);
    check(rdv, 32'h32);
    check(32'(req_cnt - req_mark), 32'd1);
    rd_chk(`OFS_DATA0_LO, 8'ha5);
    rd_chk(`OFS_DATA0_HI, 8'hc3);
    give_verdict();
  end

  initial begin
    #5000000;
    errors++;
    give_verdict();
  end
endmodule : iap_flash_self_programmer_tb
